// ### common/port_mode_pkg.sv
// package: register map, mode encodings and pin-driver bundle for the port mode logic
package port_mode_pkg;

  // ==========================================================================
  // sizes
  localparam int NUM_PORTS      = 5;
  localparam int PORT_WIDTH     = 8;
  localparam int PORT4_PINS     = 4;
  localparam int NUM_PINS       = NUM_PORTS * PORT_WIDTH;

  // ==========================================================================
  // register indices (printed offsets are not word multiples: byte address = 4 * index)
  localparam logic [7:0] IDX_PORT1_MODE_SELECT_A = 8'h91;
  localparam logic [7:0] IDX_PORT1_MODE_SELECT_B = 8'h92;
  localparam logic [7:0] IDX_PORT0_MODE_SELECT_A = 8'h93;
  localparam logic [7:0] IDX_PORT0_MODE_SELECT_B = 8'h94;
  localparam logic [7:0] IDX_PORT2_MODE_SELECT_A = 8'h95;
  localparam logic [7:0] IDX_PORT2_MODE_SELECT_B = 8'h96;
  localparam logic [7:0] IDX_PORT3_MODE_SELECT_A = 8'hB1;
  localparam logic [7:0] IDX_PORT3_MODE_SELECT_B = 8'hB2;
  localparam logic [7:0] IDX_PORT4_MODE_SELECT_A = 8'hB3;
  localparam logic [7:0] IDX_PORT4_MODE_SELECT_B = 8'hB4;

  // ==========================================================================
  // reset values and implemented-bit masks
  localparam logic [7:0] MODE_RESET   = 8'h00;
  localparam logic [7:0] FULL_MASK    = 8'hFF;
  localparam logic [7:0] PORT4_MASK   = 8'h0F;
  localparam logic [7:0] LATCH_RESET  = 8'hFF;

  // ==========================================================================
  // timing: strong pull-up kick lasts two cpu clocks
  localparam int STRONG_KICK_CYCLES = 2;

  // ==========================================================================
  // pin modes, {select_a, select_b}
  typedef enum logic [1:0] {
    MODE_QUASI      = 2'b00,
    MODE_PUSH_PULL  = 2'b01,
    MODE_HIGH_Z     = 2'b10,
    MODE_OPEN_DRAIN = 2'b11
  } pin_mode_t;

  // driver enables for one pin
  typedef struct packed {
    logic pull_down;
    logic very_weak_up;
    logic weak_up;
    logic strong_up;
  } pin_drive_t;

  // byte address from register index
  function automatic logic [9:0] reg_byte_addr(input logic [7:0] idx);
    reg_byte_addr = {idx, 2'b00};
  endfunction : reg_byte_addr

endpackage : port_mode_pkg

// ### core/pin_driver.sv
// pin driver: pull-up and pull-down enables of one pin from its mode, latch and level
`timescale 1ns/1ps
module pin_driver
  import port_mode_pkg::*;
(
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  input  wire port_mode_pkg::pin_mode_t mode,
  input  wire logic                    latch,
  input  wire logic                    pin_level,
  output      port_mode_pkg::pin_drive_t drive
);

  // ==========================================================================
  // kick counter state
  logic       latch_prev;
  logic [1:0] kick_count;
  logic       next_latch_prev;
  logic [1:0] next_kick_count;

  // a 0->1 latch change in quasi mode loads the kick counter
  always_comb begin
    next_latch_prev = latch;
    next_kick_count = kick_count;
    if (mode == MODE_QUASI && latch && !latch_prev) begin
      next_kick_count = 2'(STRONG_KICK_CYCLES);
    end else if (kick_count != 2'h0) begin
      next_kick_count = kick_count - 2'h1;
    end
    // kick is quasi-only; a zero latch cancels it so it never fights the pull-down
    if (mode != MODE_QUASI || !latch) begin
      next_kick_count = 2'h0;
    end
  end

  // latch starts at one after reset, so no kick fires at release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latch_prev <= 1'b1;
      kick_count <= 2'h0;
    end else begin
      latch_prev <= next_latch_prev;
      kick_count <= next_kick_count;
    end
  end

  // ==========================================================================
  // driver enables, registered so the outputs are flop-driven
  pin_drive_t next_drive;

  always_comb begin
    next_drive = '0;
    unique case (mode)
      MODE_QUASI: begin
        next_drive.pull_down    = !latch;
        next_drive.very_weak_up = latch;
        next_drive.weak_up      = latch && pin_level;
        next_drive.strong_up    = (next_kick_count != 2'h0);
      end
      MODE_PUSH_PULL: begin
        next_drive.pull_down = !latch;
        next_drive.strong_up = latch;
      end
      MODE_HIGH_Z: begin
        next_drive = '0;
      end
      MODE_OPEN_DRAIN: begin
        next_drive.pull_down = !latch;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drive <= '0;
    end else begin
      drive <= next_drive;
    end
  end

endmodule : pin_driver

// ### core/mode_regs_ahb.sv
// ahb-lite slave holding the ten port mode registers
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module mode_regs_ahb
  import port_mode_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output      logic [31:0] hrdata,
  output      logic        hreadyout,
  output      logic        hresp,
  output      logic [7:0]  mode_a [port_mode_pkg::NUM_PORTS],
  output      logic [7:0]  mode_b [port_mode_pkg::NUM_PORTS]
);

  // ==========================================================================
  // address decode: port number, a/b select, hit
  function automatic logic [3:0] decode(input logic [31:0] a);
    logic [9:0] ba;
    ba = a[9:0];
    decode = 4'hF;
    if (a[31:10] == 22'h0) begin
      unique case (ba)
        reg_byte_addr(IDX_PORT0_MODE_SELECT_A): decode = 4'h0;
        reg_byte_addr(IDX_PORT0_MODE_SELECT_B): decode = 4'h1;
        reg_byte_addr(IDX_PORT1_MODE_SELECT_A): decode = 4'h2;
        reg_byte_addr(IDX_PORT1_MODE_SELECT_B): decode = 4'h3;
        reg_byte_addr(IDX_PORT2_MODE_SELECT_A): decode = 4'h4;
        reg_byte_addr(IDX_PORT2_MODE_SELECT_B): decode = 4'h5;
        reg_byte_addr(IDX_PORT3_MODE_SELECT_A): decode = 4'h6;
        reg_byte_addr(IDX_PORT3_MODE_SELECT_B): decode = 4'h7;
        reg_byte_addr(IDX_PORT4_MODE_SELECT_A): decode = 4'h8;
        reg_byte_addr(IDX_PORT4_MODE_SELECT_B): decode = 4'h9;
        default: decode = 4'hF;
      endcase
    end
  endfunction : decode

  // implemented mode bits of one port: port 4 has only its low nibble
  function automatic logic [7:0] port_mask(input logic [2:0] port);
    port_mask = (port == 3'h4) ? PORT4_MASK : FULL_MASK;
  endfunction : port_mask

  // ==========================================================================
  // address-phase capture
  logic       wr_pend;
  logic [3:0] wr_sel;
  logic       next_wr_pend;
  logic [3:0] next_wr_sel;
  logic [31:0] next_hrdata;
  logic [3:0]  sel_now;
  logic        take;

  assign take    = hsel && hready && htrans[1];
  assign sel_now = decode(haddr);

  always_comb begin
    next_wr_pend = take && hwrite;
    next_wr_sel  = sel_now;
    next_hrdata  = 32'h0;
    if (take && !hwrite && sel_now != 4'hF) begin
      next_hrdata = {24'h0, sel_now[0] ? mode_b[sel_now[3:1]] : mode_a[sel_now[3:1]]};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_sel  <= 4'hF;
      hrdata  <= 32'h0;
    end else begin
      wr_pend <= next_wr_pend;
      wr_sel  <= next_wr_sel;
      hrdata  <= next_hrdata;
    end
  end

  // zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ==========================================================================
  // mode registers; port 4 keeps only its low nibble
  logic [7:0] next_a [NUM_PORTS];
  logic [7:0] next_b [NUM_PORTS];

  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      next_a[p] = mode_a[p];
      next_b[p] = mode_b[p];
    end
    if (wr_pend && wr_sel != 4'hF) begin
      if (wr_sel[0]) begin
        next_b[wr_sel[3:1]] = hwdata[7:0] & port_mask(wr_sel[3:1]);
      end else begin
        next_a[wr_sel[3:1]] = hwdata[7:0] & port_mask(wr_sel[3:1]);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        mode_a[p] <= MODE_RESET;
        mode_b[p] <= MODE_RESET;
      end
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        mode_a[p] <= next_a[p];
        mode_b[p] <= next_b[p];
      end
    end
  end

endmodule : mode_regs_ahb

// ### core/port_mode_logic.sv
// top: five-port pin mode control with ahb-lite register access
// Notes on behaviour
// - five ports 0..4, each pin takes its own mode without touching others.
// - mode bits a/b decode 00 quasi, 01 push-pull, 10 input-only, 11 open-drain.
// - ports 0..3 have eight mode bits, port 4 only bits 0..3 and its upper bits are unused.
// - quasi mode drives a one weakly high and a zero strongly low.
// - quasi mode enables the very weak pull-up while the latch is one.
// - quasi mode enables the weak pull-up only while latch and pin level are both one.
// - quasi mode turns the strong pull-up on for two clocks after the latch goes 0 to 1.
// - open-drain mode keeps pull-ups off and pulls down only while the latch is zero.
// - open-drain input sensing is the same as quasi.
// - push-pull mode drives a continuous strong pull-up for a one and the shared pull-down.
// - input-only mode enables no pull-up and no pull-down but still senses the pin.
// - after reset every mode register is zero so all pins start in quasi mode.
`timescale 1ns/1ps
module port_mode_logic
  import port_mode_pkg::*;
(
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output      logic [31:0]                hrdata,
  output      logic                       hreadyout,
  output      logic                       hresp,
  input  wire logic [port_mode_pkg::NUM_PINS-1:0] port_latch,
  input  wire logic [port_mode_pkg::NUM_PINS-1:0] pin_in,
  output      logic [port_mode_pkg::NUM_PINS-1:0] pin_sense,
  output      port_mode_pkg::pin_drive_t [port_mode_pkg::NUM_PINS-1:0] pin_drive
);

  // ==========================================================================
  // register file
  logic [7:0] mode_a [NUM_PORTS];
  logic [7:0] mode_b [NUM_PORTS];

  mode_regs_ahb u_regs (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .mode_a    (mode_a),
    .mode_b    (mode_b)
  );

  // ==========================================================================
  // input sensing: same path in every mode, registered once
  logic [NUM_PINS-1:0] next_sense;

  always_comb begin
    next_sense = pin_in;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_sense <= '0;
    end else begin
      pin_sense <= next_sense;
    end
  end

  // ==========================================================================
  // one driver per pin; port 4 upper pins stay in quasi (unused bits read zero)
  for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
    pin_mode_t m;
    assign m = pin_mode_t'({mode_a[g / PORT_WIDTH][g % PORT_WIDTH],
                            mode_b[g / PORT_WIDTH][g % PORT_WIDTH]});
    pin_driver u_pin (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .mode      (m),
      .latch     (port_latch[g]),
      .pin_level (pin_in[g]),
      .drive     (pin_drive[g])
    );
  end

endmodule : port_mode_logic

// ### bench/port_mode_logic_assertions.sv
// checker: pin 0 driver timing and bus answer relations of the port mode top
`timescale 1ns/1ps
module port_mode_logic_assertions
  import port_mode_pkg::*;
(
  input wire logic                                          hclk,
  input wire logic                                          hresetn,
  input wire logic                                          hsel,
  input wire logic [1:0]                                    htrans,
  input wire logic                                          hwrite,
  input wire logic                                          hready,
  input wire logic [31:0]                                   hrdata,
  input wire logic                                          hreadyout,
  input wire logic                                          hresp,
  input wire logic [port_mode_pkg::NUM_PINS-1:0]            port_latch,
  input wire logic [port_mode_pkg::NUM_PINS-1:0]            pin_in,
  input wire logic [port_mode_pkg::NUM_PINS-1:0]            pin_sense,
  input wire port_mode_pkg::pin_drive_t [port_mode_pkg::NUM_PINS-1:0] pin_drive
);
  // ==========================================================================
  // assertions, one clock domain
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_vweak;
    pin_drive[0].very_weak_up |-> $past(port_latch[0]);
  endproperty
  a_vweak: assert property (p_vweak) else $error("very weak pull-up without latch");
  property p_weak;
    pin_drive[0].weak_up |-> $past(port_latch[0]) && $past(pin_in[0]);
  endproperty
  a_weak: assert property (p_weak) else $error("weak pull-up with pin or latch low");
  property p_pdown;
    pin_drive[0].pull_down |->
      !$past(port_latch[0]) && !pin_drive[0].weak_up && !pin_drive[0].strong_up;
  endproperty
  a_pdown: assert property (p_pdown) else $error("pull-down fights a one");
  // a rise of the very weak pull-up with strong on marks a quasi kick
  property p_kick;
    $rose(pin_drive[0].very_weak_up) && pin_drive[0].strong_up |=>
      pin_drive[0].strong_up ##1 !pin_drive[0].strong_up;
  endproperty
  a_kick: assert property (p_kick) else $error("strong kick not two cycles");
  property p_strong;
    pin_drive[0].strong_up |-> $past(port_latch[0]);
  endproperty
  a_strong: assert property (p_strong) else $error("strong pull-up with latch low");
  // the reset cycle does not sample, so only after a running cycle
  property p_sense;
    $past(hresetn) |-> pin_sense == $past(pin_in);
  endproperty
  a_sense: assert property (p_sense) else $error("sensed level not one cycle late");
  property p_bus;
    hreadyout && !hresp;
  endproperty
  a_bus: assert property (p_bus) else $error("bus answer not ready and okay");
  property p_rdata;
    !($past(hsel) && $past(htrans[1]) && $past(hready) && !$past(hwrite)) |-> hrdata == 32'h0;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside a read phase");
  property p_upper;
    hrdata[31:8] == 24'h0;
  endproperty
  a_upper: assert property (p_upper) else $error("read data above bit 7");
endmodule : port_mode_logic_assertions

bind port_mode_logic port_mode_logic_assertions port_mode_logic_assertions_inst (
  .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
  .port_latch, .pin_in, .pin_sense, .pin_drive);

// ### bench/pin_world.sv
// partner: external devices and wiring on the port pins
`timescale 1ns/1ps
module pin_world
  import port_mode_pkg::*;
(
  input  wire logic                                          hclk,
  input  wire port_mode_pkg::pin_drive_t [port_mode_pkg::NUM_PINS-1:0] pin_drive,
  input  wire logic [port_mode_pkg::NUM_PINS-1:0]            ext_low,
  output      logic [port_mode_pkg::NUM_PINS-1:0]            pin_in
);
  logic [NUM_PINS-1:0] float_level = '0;

  // a floating pin toggles so an unknown never settles to a lucky value
  always_ff @(posedge hclk) float_level <= ~pin_in;

  // external sink beats every pull-up; otherwise any pull-up wins
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (ext_low[i]) pin_in[i] = 1'b0;
      else if (pin_drive[i].strong_up || pin_drive[i].weak_up || pin_drive[i].very_weak_up)
        pin_in[i] = 1'b1;
      else if (pin_drive[i].pull_down) pin_in[i] = 1'b0;
      else pin_in[i] = float_level[i];
    end
  end
endmodule : pin_world

// ### bench/configurable_port_mode_logic_bench.sv
// testbench: register access and pin driver behaviour of the port mode logic
`timescale 1ns/1ps
module configurable_port_mode_logic_bench;
  import port_mode_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [NUM_PINS-1:0] port_latch, pin_in, pin_sense, ext_low;
  pin_drive_t [NUM_PINS-1:0] pin_drive;
  int comparisons, fail_count;
  logic [7:0] regs [10] = '{IDX_PORT1_MODE_SELECT_A, IDX_PORT1_MODE_SELECT_B,
    IDX_PORT0_MODE_SELECT_A, IDX_PORT0_MODE_SELECT_B, IDX_PORT2_MODE_SELECT_A,
    IDX_PORT2_MODE_SELECT_B, IDX_PORT3_MODE_SELECT_A, IDX_PORT3_MODE_SELECT_B,
    IDX_PORT4_MODE_SELECT_A, IDX_PORT4_MODE_SELECT_B};
  // {pull_down, very_weak, weak, strong} for quasi, push-pull, input-only, open-drain
  logic [3:0] hi_exp [4] = '{4'h6, 4'h1, 4'h0, 4'h0};
  logic [3:0] lo_exp [4] = '{4'h8, 4'h8, 4'h0, 4'h8};

  port_mode_logic port_mode_logic_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .port_latch,
    .pin_in, .pin_sense, .pin_drive);
  pin_world pin_world_inst (.hclk, .pin_drive, .ext_low, .pin_in);

  always #12.5 hclk = ~hclk;

  // ==========================================================================
  // bus cycle: address phase, then data phase; both end on a sampled hready
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rdv);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask : bus

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic dchk(input int pin, input logic [3:0] exp);
    check({28'h0, pin_drive[pin]}, {28'h0, exp});
  endtask : dchk

  task automatic final_report;
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report

  // watchdog: the whole sequence needs about 110 cycles
  initial begin
    repeat (3000) @(posedge hclk);
    fail_count++;
    final_report();
  end

  initial begin
    logic [7:0] v;
    {hclk, hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    {port_latch, ext_low, comparisons, fail_count} = '0;
    hsize = 3'h2;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b1, 8'h20, 32'hFF, rd);
    bus(1'b0, 8'h20, 32'h0, rd);
    check(rd, 32'h0);
    foreach (regs[i]) begin
      bus(1'b0, regs[i], 32'h0, rd);
      check(rd, 32'h0);
    end
    foreach (regs[i]) bus(1'b1, regs[i], 32'hFFFFFF5A + i, rd);
    foreach (regs[i]) begin
      v = 8'h5A + 8'(i);
      bus(1'b0, regs[i], 32'h0, rd);
      check(rd, {24'h0, v & (i >= 8 ? PORT4_MASK : FULL_MASK)});
    end
    foreach (regs[i]) bus(1'b1, regs[i], 32'h0, rd);
    @(posedge hclk);
    #1 dchk(0, 4'h8);
    // latch rise in quasi mode: two-cycle kick, weak follows the pin a cycle later
    @(posedge hclk) port_latch <= '1;
    @(posedge hclk);
    #1 dchk(0, 4'h5);
    @(posedge hclk);
    #1 dchk(0, 4'h7);
    @(posedge hclk);
    #1 dchk(0, 4'h6);
    @(posedge hclk) ext_low[0] <= 1'b1;
    @(posedge hclk);
    #1 dchk(0, 4'h4);
    check({31'h0, pin_sense[0]}, 32'h0);
    @(posedge hclk) ext_low[0] <= 1'b0;
    @(posedge hclk);
    #1 dchk(0, 4'h6);
    // port 1 pins 0..3 take the four modes, pin 4 stays quasi
    bus(1'b1, IDX_PORT1_MODE_SELECT_A, 32'h0C, rd);
    bus(1'b1, IDX_PORT1_MODE_SELECT_B, 32'h0A, rd);
    @(posedge hclk);
    #1 for (int p = 0; p < 4; p++) dchk(8 + p, hi_exp[p]);
    dchk(12, 4'h6);
    @(posedge hclk) port_latch <= '0;
    @(posedge hclk);
    #1 for (int p = 0; p < 4; p++) dchk(8 + p, lo_exp[p]);
    // a latch that falls inside the kick ends it: pull-down alone, no strong fight
    @(posedge hclk) port_latch[8] <= 1'b1;
    @(posedge hclk) port_latch[8] <= 1'b0;
    #1 dchk(8, 4'h5);
    @(posedge hclk);
    #1 dchk(8, 4'h8);
    final_report();
  end
endmodule : configurable_port_mode_logic_bench
